//--- verification/tb.sv
// Self-checking bench for the fault power-down and power-tune register bank.
// Assumes the strobe register port and fault timing given in the design notes.
`timescale 1ns/1ps
module tb;
	import dfpt_pkg::*;

	logic       core_clk         = 1'b0;
	logic       sys_rst          = 1'b1;
	logic [7:0] reg_addr         = 8'h00;
	logic       reg_wr           = 1'b0;
	logic [7:0] reg_wdata        = 8'h00;
	logic       reg_rd           = 1'b0;
	logic [1:0] drv_gate_fault   = 2'h0;
	logic [1:0] drv_short_fault  = 2'h0;
	logic       areg_short_fault = 1'b0;
	logic [1:0] fault_unmasked   = 2'h3;
	logic [1:0] ch_enable        = 2'h3;
	logic [1:0] ch_powering_up   = 2'h0;
	logic [7:0] reg_rdata;
	logic [1:0] ch_power_en;
	logic       fault_powerdown_flag;
	logic [1:0] mic_lvl, ref_fs;
	logic       mic_gain, r_clk, r_cic, r_fir, r_dem, r_lpf, p_clk, p_dem, p_lpf, p_iref;
	int         n_fail          = 0;
	int         samples_checked = 0;
	logic [7:0] mdl  [5];
	logic [7:0] wmk  [5] = '{WM_FLT, WM_REF, WM_PT0, WM_PT1, 8'h00};
	logic [7:0] adrs [5] = '{ADDR_FLT, ADDR_REF, ADDR_PT0, ADDR_PT1, 8'h44};
	logic [31:0] lf = 32'hEF8A5037;

	// Free-running 100 MHz clock.
	always #5 core_clk = ~core_clk;

	dfpt_regs #(.NCH(2)) dut (
		.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.drv_gate_fault(drv_gate_fault), .drv_short_fault(drv_short_fault),
		.areg_short_fault(areg_short_fault), .fault_unmasked(fault_unmasked),
		.ch_enable(ch_enable), .ch_powering_up(ch_powering_up), .ch_power_en(ch_power_en),
		.fault_powerdown_flag(fault_powerdown_flag), .mic_supply_level_select(mic_lvl),
		.mic_supply_regulator_gain(mic_gain), .reference_fullscale_select(ref_fs),
		.record_modclk_halve(r_clk), .record_decimator_order(r_cic), .record_fir_skip(r_fir),
		.record_matching_rate_double(r_dem), .record_lowpower_filter(r_lpf),
		.playback_modclk_halve(p_clk), .playback_matching_rate_double(p_dem),
		.playback_lowpower_filter(p_lpf), .playback_current_ref_select(p_iref)
	);

	// Fibonacci-style shift register; one step per random value.
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// Model slot of an address; slot 4 stands for every unmapped address.
	function automatic int idx(input logic [7:0] a);
		case (a)
			8'h43:   idx = 0;
			8'h4D:   idx = 1;
			8'h4E:   idx = 2;
			8'h4F:   idx = 3;
			default: idx = 4;
		endcase
	endfunction

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Write strobe for one cycle; the model keeps only the writable bits.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int i;
		i = idx(a);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		mdl[i] = (mdl[i] & ~wmk[i]) | (d & wmk[i]);
	endtask

	// Read strobe for one cycle; data is valid at the following falling edge.
	task automatic rd(input logic [7:0] a, input logic flag);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		check(reg_rdata, mdl[idx(a)] | {4'h0, flag, 3'h0});
	endtask

	// Configuration outputs mirror their register bits.
	task automatic chk_out();
		check({3'h0, mic_gain, mic_lvl, ref_fs}, mdl[1] & 8'h1F);
		check({r_clk, r_cic, r_fir, r_dem, 1'b0, r_lpf, 2'h0}, mdl[2]);
		check({p_clk, 2'h0, p_dem, 1'b0, p_lpf, p_iref, 1'b0}, mdl[3]);
	endtask

	// Bounded wait for channel 0 power enable to reach a level.
	task automatic wait_en(input logic v, output logic ok);
		ok = 1'b0;
		for (int k = 0; k < 12 && !ok; k++) begin
			@(negedge core_clk);
			ok = (ch_power_en[0] === v);
		end
	endtask

	// One fault scenario on channel 0: pins are gate, short, regulator short.
	task automatic flt(input logic [7:0] cfg, input logic [2:0] pins, input logic unm,
		input logic pu, input logic exp);
		logic ok;
		wr(8'h43, cfg);
		fault_unmasked = {1'b1, unm};
		ch_powering_up = {1'b0, pu};
		{drv_gate_fault[0], drv_short_fault[0], areg_short_fault} = pins;
		wait_en(1'b0, ok);
		check({7'h0, ok}, {7'h0, exp});
		if (ok) begin
			repeat (3) @(negedge core_clk);
			check({7'h0, fault_powerdown_flag}, 8'h01);
			// Only a regulator short takes channel 1 down together with channel 0.
			check({6'h0, ch_power_en}, {6'h0, ~pins[0], 1'b0});
			rd(8'h43, 1'b1);
		end
		{drv_gate_fault[0], drv_short_fault[0], areg_short_fault} = 3'h0;
		repeat (12) @(negedge core_clk);
		// Manual recovery needs a low pulse on the channel enable.
		if (ok && cfg[4]) begin
			check({7'h0, ch_power_en[0]}, 8'h00);
			// A regulator short holds every channel, so every enable is pulsed.
			ch_enable = 2'h0;
			@(negedge core_clk);
			ch_enable = 2'h3;
		end
		wait_en(1'b1, ok);
		check({7'h0, ok}, 8'h01);
		if (!ok) begin
			print_verdict();
		end
		repeat (3) @(negedge core_clk);
		rd(8'h43, 1'b0);
		ch_powering_up = 2'h0;
	endtask

	// Main sequence: reset, register access, then the fault table.
	initial begin
		mdl = '{RST_FLT, RST_REF, RST_PT0, RST_PT1, 8'h00};
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		sys_rst = 1'b0;
		// Reset values, including an unmapped address.
		for (int k = 0; k < 5; k++) begin
			rd(adrs[k], 1'b0);
		end
		chk_out();
		$display("test reset_values done");
		// Random writes reach reserved and read-only bits too.
		for (int r = 0; r < 40; r++) begin
			lf = lfsr(lf);
			wr(adrs[r % 5], lf[7:0]);
			rd(adrs[r % 5], 1'b0);
			chk_out();
		end
		$display("test register_access done");
		// A reset in mid-run restores every register.
		@(negedge core_clk);
		sys_rst = 1'b1;
		repeat (3) @(negedge core_clk);
		sys_rst = 1'b0;
		mdl = '{RST_FLT, RST_REF, RST_PT0, RST_PT1, 8'h00};
		for (int k = 0; k < 5; k++) begin
			rd(adrs[k], 1'b0);
		end
		chk_out();
		$display("test mid_reset done");
		// Fault selection codes and unmasked filter.
		flt(8'h40, 3'h4, 1'b1, 1'b0, 1'b1);
		flt(8'h00, 3'h4, 1'b1, 1'b0, 1'b0);
		flt(8'h60, 3'h2, 1'b1, 1'b0, 1'b0);
		flt(8'h20, 3'h4, 1'b0, 1'b0, 1'b0);
		flt(8'h20, 3'h2, 1'b1, 1'b0, 1'b1);
		// Detection disables for driver and regulator faults, then the power-up gate skip.
		flt(8'h42, 3'h4, 1'b1, 1'b0, 1'b0);
		flt(8'h42, 3'h2, 1'b1, 1'b0, 1'b0);
		flt(8'h41, 3'h1, 1'b1, 1'b0, 1'b0);
		flt(8'h40, 3'h1, 1'b1, 1'b0, 1'b1);
		flt(8'h44, 3'h4, 1'b1, 1'b1, 1'b0);
		flt(8'h40, 3'h4, 1'b1, 1'b1, 1'b1);
		flt(8'h44, 3'h2, 1'b1, 1'b1, 1'b1);
		// Manual recovery keeps the channel down.
		flt(8'h50, 3'h4, 1'b1, 1'b0, 1'b1);
		flt(8'h54, 3'h1, 1'b1, 1'b0, 1'b1);
		$display("test fault_powerdown done");
		print_verdict();
	end
endmodule // tb

//--- verilog/dfpt_fault_ctrl.sv
// Per-channel playback power-down on fault, with auto or manual recovery.
// Assumes fault levels are already synchronised to core_clk.
`timescale 1ns/1ps
module dfpt_fault_ctrl
	import dfpt_pkg::*;
#(
	parameter int NCH = 2
) (
	input wire logic    core_clk,
	input wire logic    sys_rst,
	dfpt_fault_if.ctrl  fb
);

	logic [NCH-1:0] held_q;
	logic [NCH-1:0] held_d;
	logic [NCH-1:0] pwr_q;
	logic [NCH-1:0] pwr_d;

	// [RULE_04] Gate fault during power-up.
	// Gate and short faults are dropped when detection is off; a gate fault
	// on a channel that is powering up is dropped when the skip bit is set.
	wire logic [NCH-1:0] gate_ok  = fb.gate_flt & ~{NCH{fb.det_dis}}
		& ~(fb.powering_up & {NCH{fb.skip_pu}});
	// [RULE_05] Driver detect disable.
	wire logic [NCH-1:0] short_ok = fb.short_flt & ~{NCH{fb.det_dis}};
	// [RULE_06] Regulator detect disable.
	wire logic [NCH-1:0] areg_ok  = {NCH{fb.areg_flt & ~fb.areg_dis}};
	wire logic [NCH-1:0] any_flt  = gate_ok | short_ok | areg_ok;

	// [RULE_01] Fault selection code.
	// The reserved code behaves like "ignore" so a bad write cannot trip.
	wire logic [NCH-1:0] trip =
		(fb.sel == DFPT_SEL_ALL)      ? any_flt :
		(fb.sel == DFPT_SEL_UNMASKED) ? (any_flt & fb.unmasked) : '0;

	// [RULE_02] Auto or manual recovery.
	// [RULE_21] Manual hold until disabled.
	// A new trip always wins over release, so no fault is lost.
	assign held_d = trip | (held_q & fb.ch_enable & {NCH{fb.manual}});
	assign pwr_d  = fb.ch_enable & ~held_d;

	// Hold state and channel power enables.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			held_q <= '0;
			pwr_q  <= '0;
		end else begin
			held_q <= held_d;
			pwr_q  <= pwr_d;
		end
	end

	assign fb.held     = held_q;
	assign fb.power_en = pwr_q;

endmodule // dfpt_fault_ctrl

//--- verilog/dfpt_fault_if.sv
// Carries fault configuration and filtered fault levels from the register
// bank to the channel power-down logic, and the hold state back.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface dfpt_fault_if #(parameter int NCH = 2);
	logic [1:0]     sel;
	logic           manual;
	logic           skip_pu;
	logic           det_dis;
	logic           areg_dis;
	logic           areg_flt;
	logic [NCH-1:0] gate_flt;
	logic [NCH-1:0] short_flt;
	logic [NCH-1:0] unmasked;
	logic [NCH-1:0] powering_up;
	logic [NCH-1:0] ch_enable;
	logic [NCH-1:0] held;
	logic [NCH-1:0] power_en;

	modport cfg (output sel, manual, skip_pu, det_dis, areg_dis, areg_flt, gate_flt,
		short_flt, unmasked, powering_up, ch_enable, input held, power_en);
	modport ctrl (input sel, manual, skip_pu, det_dis, areg_dis, areg_flt, gate_flt,
		short_flt, unmasked, powering_up, ch_enable, output held, power_en);
endinterface

//--- verilog/dfpt_pkg.sv
// Register map, field positions, reset values and codes for the playback
// fault power-down, reference bias and power-tune configuration slice.
// Assumes an 8-bit register address and 8-bit registers on the control port.
package dfpt_pkg;

	// Register addresses.
	localparam logic [7:0] ADDR_FLT = 8'h43;
	localparam logic [7:0] ADDR_REF = 8'h4D;
	localparam logic [7:0] ADDR_PT0 = 8'h4E;
	localparam logic [7:0] ADDR_PT1 = 8'h4F;

	// Reset values.
	localparam logic [7:0] RST_FLT = 8'h54;
	localparam logic [7:0] RST_REF = 8'h00;
	localparam logic [7:0] RST_PT0 = 8'h00;
	localparam logic [7:0] RST_PT1 = 8'h00;

	// Writable bits; all others are read-only.
	localparam logic [7:0] WM_FLT = 8'h77;
	localparam logic [7:0] WM_REF = 8'h1F;
	localparam logic [7:0] WM_PT0 = 8'hF4;
	localparam logic [7:0] WM_PT1 = 8'h96;

	// Fault power-down configuration fields.
	localparam int FLT_SEL_LSB  = 5;
	localparam int FLT_RCV_BIT  = 4;
	localparam int FLT_STS_BIT  = 3;
	localparam int FLT_SKIP_BIT = 2;
	localparam int FLT_DDIS_BIT = 1;
	localparam int FLT_ADIS_BIT = 0;

	// Reference and microphone supply fields.
	localparam int REF_GAIN_BIT = 4;
	localparam int REF_MIC_LSB  = 2;
	localparam int REF_FS_LSB   = 0;

	// Record power-tune fields.
	localparam int PT0_CLK_BIT = 7;
	localparam int PT0_CIC_BIT = 6;
	localparam int PT0_FIR_BIT = 5;
	localparam int PT0_DEM_BIT = 4;
	localparam int PT0_LPF_BIT = 2;

	// Playback power-tune fields.
	localparam int PT1_CLK_BIT  = 7;
	localparam int PT1_DEM_BIT  = 4;
	localparam int PT1_LPF_BIT  = 2;
	localparam int PT1_IREF_BIT = 1;

	// Number of synchroniser stages on fault pins.
	localparam int SYNC_STAGES = 3;

	// Fault selection codes for playback power-down.
	typedef enum logic [1:0] {
		DFPT_SEL_NONE     = 2'h0,
		DFPT_SEL_UNMASKED = 2'h1,
		DFPT_SEL_ALL      = 2'h2,
		DFPT_SEL_RSVD     = 2'h3
	} dfpt_sel_t;

	// Merge a write into a register, touching only the writable bits.
	function automatic logic [7:0] dfpt_merge(input logic [7:0] old_v,
		input logic [7:0] wr_v, input logic [7:0] mask_v);
		dfpt_merge = (old_v & ~mask_v) | (wr_v & mask_v);
	endfunction

endpackage

//--- verilog/dfpt_regs.sv
// Register bank for playback fault power-down, reference and microphone
// supply selection, and record/playback power-tune options.
// Assumes a simple register port from the control interface decoder,
// fault pins from the analog side, and channel controls on core_clk.
`timescale 1ns/1ps

// How it works
// [RULE_01] Two-bit code picks none, unmasked or all faults; reset code 2.
// [RULE_02] Recovery bit 0 re-powers after fault clears; 1 keeps off; reset 1.
// [RULE_03] Read-only bit 3 is set while any channel is held down.
// [RULE_04] Bit 2 set ignores gate faults during channel power-up; reset 1.
// [RULE_05] Bit 1 set disables playback gate and short fault detection.
// [RULE_06] Bit 0 set disables regulator short detection.
// [RULE_07] Reserved bits read zero, are read-only; software writes zero.
// [RULE_08] Mic supply code: reference, half reference, reserved, bypass.
// [RULE_09] Reference register bit 4 sets mic regulator gain to 1.096.
// [RULE_10] Two-bit full-scale code picks 2.75, 2.5 or 1.375 V.
// [RULE_11] Record modulator clock halves when its select bit is 1.
// [RULE_12] Record tune bit 6 picks fourth order decimator when set.
// [RULE_13] Record tune bit 5 bypasses the record FIR when set.
// [RULE_14] Record tune bit 4 doubles record element matching rate.
// [RULE_15] Record tune bit 2 enables the record low-power filter.
// [RULE_16] Playback modulator clock goes 3 to 1.5 MHz when set.
// [RULE_17] Playback tune bit 4 doubles playback element matching rate.
// [RULE_18] Playback tune bit 2 enables the playback low-power filter.
// [RULE_19] Playback tune bit 1 picks reference over 2R current.
// [RULE_20] Fault register at 0x43 resets to 0x54; others reset to zero.
// [RULE_21] Manual mode keeps a tripped channel down until software disables it.
module dfpt_regs
	import dfpt_pkg::*;
#(
	parameter int NCH = 2
) (
	input  wire logic           core_clk,
	input  wire logic           sys_rst,
	input  wire logic [7:0]     reg_addr,
	input  wire logic           reg_wr,
	input  wire logic [7:0]     reg_wdata,
	input  wire logic           reg_rd,
	output logic      [7:0]     reg_rdata,
	input  wire logic [NCH-1:0] drv_gate_fault,
	input  wire logic [NCH-1:0] drv_short_fault,
	input  wire logic           areg_short_fault,
	input  wire logic [NCH-1:0] fault_unmasked,
	input  wire logic [NCH-1:0] ch_enable,
	input  wire logic [NCH-1:0] ch_powering_up,
	output logic      [NCH-1:0] ch_power_en,
	output logic                fault_powerdown_flag,
	output logic      [1:0]     mic_supply_level_select,
	output logic                mic_supply_regulator_gain,
	output logic      [1:0]     reference_fullscale_select,
	output logic                record_modclk_halve,
	output logic                record_decimator_order,
	output logic                record_fir_skip,
	output logic                record_matching_rate_double,
	output logic                record_lowpower_filter,
	output logic                playback_modclk_halve,
	output logic                playback_matching_rate_double,
	output logic                playback_lowpower_filter,
	output logic                playback_current_ref_select
);

	localparam int FW = 2 * NCH + 1;

	logic [7:0]    flt_q;
	logic [7:0]    flt_d;
	logic [7:0]    ref_q;
	logic [7:0]    ref_d;
	logic [7:0]    pt0_q;
	logic [7:0]    pt0_d;
	logic [7:0]    pt1_q;
	logic [7:0]    pt1_d;
	logic [7:0]    rdata_q;
	logic [7:0]    rdata_d;
	logic          flag_q;
	logic [FW-1:0] sync1_q;
	logic [FW-1:0] sync2_q;
	logic [FW-1:0] sync3_q;
	logic [FW-1:0] filt_q;
	logic [FW-1:0] filt_d;

	dfpt_fault_if #(.NCH(NCH)) fb ();

	// Address decode for the four registers.
	wire logic hit_flt = (reg_addr == ADDR_FLT);
	wire logic hit_ref = (reg_addr == ADDR_REF);
	wire logic hit_pt0 = (reg_addr == ADDR_PT0);
	wire logic hit_pt1 = (reg_addr == ADDR_PT1);

	// [RULE_07] Reserved bits stay zero.
	// Writes only reach writable bits, so reserved and status bits can never
	// be loaded, whatever software sends.
	assign flt_d = (reg_wr && hit_flt) ? dfpt_merge(flt_q, reg_wdata, WM_FLT) : flt_q;
	assign ref_d = (reg_wr && hit_ref) ? dfpt_merge(ref_q, reg_wdata, WM_REF) : ref_q;
	assign pt0_d = (reg_wr && hit_pt0) ? dfpt_merge(pt0_q, reg_wdata, WM_PT0) : pt0_q;
	assign pt1_d = (reg_wr && hit_pt1) ? dfpt_merge(pt1_q, reg_wdata, WM_PT1) : pt1_q;

	// [RULE_20] Register reset values.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			flt_q <= RST_FLT;
			ref_q <= RST_REF;
			pt0_q <= RST_PT0;
			pt1_q <= RST_PT1;
		end else begin
			flt_q <= flt_d;
			ref_q <= ref_d;
			pt0_q <= pt0_d;
			pt1_q <= pt1_d;
		end
	end

	// [RULE_03] Live status bit.
	// The status bit is inserted on read; unmapped addresses return zero.
	wire logic [7:0] flt_view = flt_q | (8'(flag_q) << FLT_STS_BIT);
	wire logic [7:0] rd_mux   = hit_flt ? flt_view :
		hit_ref ? ref_q :
		hit_pt0 ? pt0_q :
		hit_pt1 ? pt1_q : 8'h00;
	assign rdata_d = reg_rd ? rd_mux : rdata_q;

	// Read data is captured on the read strobe and held until the next read.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Fault pins are asynchronous to core_clk: three stages, and a level only
	// counts once the second and third stages agree, which also drops
	// single-cycle glitches from the analog comparators.
	wire logic [FW-1:0] pins = {areg_short_fault, drv_short_fault, drv_gate_fault};
	assign filt_d = (sync2_q & sync3_q) | (filt_q & (sync2_q | sync3_q));

	// Synchroniser chain and agreement filter.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
			filt_q  <= '0;
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			filt_q  <= filt_d;
		end
	end

	// [RULE_01] Fault selection code.
	// [RULE_02] Recovery mode bit.
	// Configuration and filtered faults feed the channel power-down logic.
	assign fb.sel         = flt_q[FLT_SEL_LSB +: 2];
	assign fb.manual      = flt_q[FLT_RCV_BIT];
	// [RULE_04] Skip during power-up.
	assign fb.skip_pu     = flt_q[FLT_SKIP_BIT];
	// [RULE_05] Driver detect disable.
	assign fb.det_dis     = flt_q[FLT_DDIS_BIT];
	// [RULE_06] Regulator detect disable.
	assign fb.areg_dis    = flt_q[FLT_ADIS_BIT];
	assign fb.gate_flt    = filt_q[NCH-1:0];
	assign fb.short_flt   = filt_q[2*NCH-1:NCH];
	assign fb.areg_flt    = filt_q[FW-1];
	assign fb.unmasked    = fault_unmasked;
	assign fb.powering_up = ch_powering_up;
	assign fb.ch_enable   = ch_enable;

	dfpt_fault_ctrl #(
		.NCH(NCH)
	) u_fault_ctrl (
		.core_clk(core_clk),
		.sys_rst (sys_rst),
		.fb      (fb)
	);

	// [RULE_03] Fault hold summary.
	// Registered so the status bit and the output flag share one source.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= |fb.held;
		end
	end

	// Outputs; all come straight from flip-flops.
	assign reg_rdata            = rdata_q;
	assign ch_power_en          = fb.power_en;
	assign fault_powerdown_flag = flag_q;

	// [RULE_08] Mic supply selection.
	// Half reference with the 1.375 V full scale is software's to avoid.
	assign mic_supply_level_select    = ref_q[REF_MIC_LSB +: 2];
	// [RULE_09] Mic regulator gain.
	assign mic_supply_regulator_gain  = ref_q[REF_GAIN_BIT];
	// [RULE_10] Reference full scale.
	assign reference_fullscale_select = ref_q[REF_FS_LSB +: 2];

	// [RULE_11] Record clock halving.
	assign record_modclk_halve         = pt0_q[PT0_CLK_BIT];
	// [RULE_12] Decimator order select.
	assign record_decimator_order      = pt0_q[PT0_CIC_BIT];
	// [RULE_13] Record FIR bypass.
	assign record_fir_skip             = pt0_q[PT0_FIR_BIT];
	// [RULE_14] Record matching rate.
	assign record_matching_rate_double = pt0_q[PT0_DEM_BIT];
	// [RULE_15] Record low-power filter.
	assign record_lowpower_filter      = pt0_q[PT0_LPF_BIT];

	// [RULE_16] Playback clock halving.
	assign playback_modclk_halve         = pt1_q[PT1_CLK_BIT];
	// [RULE_17] Playback matching rate.
	assign playback_matching_rate_double = pt1_q[PT1_DEM_BIT];
	// [RULE_18] Playback low-power filter.
	assign playback_lowpower_filter      = pt1_q[PT1_LPF_BIT];
	// [RULE_19] Playback current reference.
	assign playback_current_ref_select   = pt1_q[PT1_IREF_BIT];

	// Checks on the register bank and power-down behaviour.
	default clocking dfpt_cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	// Registers take documented values on leaving reset.
	chk_reset_values: assert property ( // [RULE_20]
		$fell(sys_rst) |-> (flt_q == RST_FLT) && (ref_q == RST_REF)
			&& (pt0_q == RST_PT0) && (pt1_q == RST_PT1))
		else $error("Register reset values wrong.");

	// Reserved bits of the record tune register read zero after any read.
	chk_reserved_zero: assert property ( // [RULE_07]
		(reg_rd && hit_pt0) |=> (reg_rdata[3] == 1'b0) && (reg_rdata[1:0] == 2'h0))
		else $error("Reserved record tune bits not zero.");

	// Status bit read back follows the hold summary of the previous cycle.
	chk_status_read: assert property ( // [RULE_03]
		(reg_rd && hit_flt) |=> reg_rdata[FLT_STS_BIT] == $past(flag_q))
		else $error("Fault status bit mismatch.");

	// A held channel is never powered.
	chk_held_unpowered: assert property ( // [RULE_01]
		(fb.held & fb.power_en) == '0)
		else $error("Held channel still powered.");

	// Ignoring faults in auto mode leaves nothing held.
	chk_ignore_faults: assert property ( // [RULE_01]
		(fb.sel == DFPT_SEL_NONE && !fb.manual) |=> fb.held == '0)
		else $error("Channel held while faults ignored.");

	// In auto mode a channel is released one cycle after its fault clears.
	chk_auto_release: assert property ( // [RULE_02]
		(!fb.manual && fb.gate_flt == '0 && fb.short_flt == '0 && !fb.areg_flt)
		|=> fb.held == '0)
		else $error("Auto recovery did not release channel.");

	// In manual mode an enabled held channel stays held.
	chk_manual_hold: assert property ( // [RULE_21]
		(fb.manual && fb.held[0] && fb.ch_enable[0]) |=> fb.held[0])
		else $error("Manual recovery released channel early.");

	// With all faults counting and detection on, a gate fault outside the power-up exception trips channel 0.
	chk_gate_trip: assert property ( // [RULE_04]
		(fb.sel == DFPT_SEL_ALL && !fb.det_dis && fb.gate_flt[0]
			&& !(fb.skip_pu && fb.powering_up[0])) |=> fb.held[0])
		else $error("Gate fault did not power down channel.");

	// With both detections off, auto mode holds nothing.
	chk_detect_off: assert property ( // [RULE_05]
		(fb.det_dis && fb.areg_dis && !fb.manual) |=> fb.held == '0)
		else $error("Channel held with detection disabled.");

	// A write to the record tune register reaches its output next cycle.
	chk_fir_write: assert property ( // [RULE_13]
		(reg_wr && hit_pt0) |=> record_fir_skip == $past(reg_wdata[PT0_FIR_BIT]))
		else $error("Record FIR bypass not written.");

	// A regulator short trips every channel when all faults count.
	chk_areg_trip: assert property ( // [RULE_06]
		(fb.sel == DFPT_SEL_ALL && fb.areg_flt && !fb.areg_dis) |=> &fb.held)
		else $error("Regulator short did not power down.");

	// A masked channel is never tripped while only unmasked faults count.
	chk_unmasked_only: assert property ( // [RULE_01]
		(fb.sel == DFPT_SEL_UNMASKED && !fb.manual && !fb.unmasked[0]) |=> !fb.held[0])
		else $error("Masked fault powered down channel.");

	// Power enable follows the previous cycle's request, less any hold.
	chk_power_follow: assert property ( // [RULE_02]
		!sys_rst |=> fb.power_en == ($past(fb.ch_enable) & ~fb.held))
		else $error("Channel power enable wrong.");

	// In manual mode a low enable with every fault gone releases the hold.
	chk_manual_release: assert property ( // [RULE_21]
		(fb.manual && !fb.ch_enable[0] && fb.gate_flt == '0 && fb.short_flt == '0
			&& !fb.areg_flt) |=> !fb.held[0])
		else $error("Manual recovery did not release channel.");

	// The flag rises the cycle after any channel is held.
	chk_flag_set: assert property ( // [RULE_03]
		(fb.held != '0) |=> fault_powerdown_flag)
		else $error("Fault power-down flag not set.");

	// The flag falls the cycle after no channel is held.
	chk_flag_clear: assert property ( // [RULE_03]
		(fb.held == '0) |=> !fault_powerdown_flag)
		else $error("Fault power-down flag not cleared.");

	// A reference register write reaches the mic supply level next cycle.
	chk_mic_level: assert property ( // [RULE_08]
		(reg_wr && hit_ref)
		|=> mic_supply_level_select == $past(reg_wdata[REF_MIC_LSB +: 2]))
		else $error("Mic supply level not written.");

	// A reference register write reaches the mic regulator gain next cycle.
	chk_mic_gain: assert property ( // [RULE_09]
		(reg_wr && hit_ref)
		|=> mic_supply_regulator_gain == $past(reg_wdata[REF_GAIN_BIT]))
		else $error("Mic regulator gain not written.");

	// A reference register write reaches the full-scale select next cycle.
	chk_fullscale: assert property ( // [RULE_10]
		(reg_wr && hit_ref)
		|=> reference_fullscale_select == $past(reg_wdata[REF_FS_LSB +: 2]))
		else $error("Reference full scale not written.");

	// A record tune write reaches the modulator clock halving next cycle.
	chk_rec_clock: assert property ( // [RULE_11]
		(reg_wr && hit_pt0)
		|=> record_modclk_halve == $past(reg_wdata[PT0_CLK_BIT]))
		else $error("Record clock halving not written.");

	// A record tune write reaches the decimator order next cycle.
	chk_rec_order: assert property ( // [RULE_12]
		(reg_wr && hit_pt0)
		|=> record_decimator_order == $past(reg_wdata[PT0_CIC_BIT]))
		else $error("Record decimator order not written.");

	// A playback tune write reaches the modulator clock halving next cycle.
	chk_play_clock: assert property ( // [RULE_16]
		(reg_wr && hit_pt1)
		|=> playback_modclk_halve == $past(reg_wdata[PT1_CLK_BIT]))
		else $error("Playback clock halving not written.");

	// A playback tune write reaches the current reference select next cycle.
	chk_play_iref: assert property ( // [RULE_19]
		(reg_wr && hit_pt1)
		|=> playback_current_ref_select == $past(reg_wdata[PT1_IREF_BIT]))
		else $error("Playback current reference not written.");

	// Reserved top bits of the reference register read zero after any read.
	chk_ref_reserved: assert property ( // [RULE_07]
		(reg_rd && hit_ref) |=> reg_rdata[7:5] == 3'h0)
		else $error("Reserved reference bits not zero.");

endmodule // dfpt_regs
